/* rtl/cfg_store.sv */
/*
 * configuration store of a small registered logic array: fuse map, user signature,
 * security cell, automatic erase, output register preload and power-up reset.
 * assumes an apb master on pclk, array next-state logic outside, inputs synchronous to pclk.
 */
// Chosen here: the address map and register access over APB.
// Function
// - a 64-bit reprogrammable user signature store holds arbitrary user data.
// - signature reads always return the stored contents whatever the security cell holds.
// - the full map has 5892 fuses with signature, a 5828-fuse standard map leaves the signature unused.
// - once the security cell is set, readback of functional fuses is refused.
// - the security cell clears as soon as a new programming cycle is started.
// - every programming cycle erases the configuration by itself, with no separate erase step.
// - each registered output can be forced high or low synchronously for test.
// - at power-up every register reads low, within the power-up reset time.
// - after power-up each registered pin shows the level set by its programmed polarity.
// - an unconnected input or i/o pin reads as logic 1.
`timescale 1ns/1ps
module cfg_store
	import cfg_store_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [NUM_REGS-1:0] next_state,
	input wire logic [NUM_INPUTS-1:0] in_val,
	input wire logic [NUM_INPUTS-1:0] in_driven,
	output logic [NUM_INPUTS-1:0] in_level,
	output logic [NUM_REGS-1:0] reg_q,
	output logic [NUM_REGS-1:0] pin_out
);
	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {PROG_IDLE, PROG_ERASE, PROG_OPEN} prog_state_t;
	prog_state_t prog_state;
	logic [FUSE_AW-1:0] erase_idx;
	logic [FUSE_AW-1:0] fuse_addr;
	logic [31:0] fuse_rdata;
	logic secure;
	logic full_map;
	logic refused;
	logic [SIG_BITS-1:0] sig;
	logic [NUM_REGS-1:0] polarity;
	logic [NUM_REGS-1:0] preload_val;
	logic preload_go;
	logic [POR_CNT_W-1:0] por_cnt;
	logic por_busy;
	logic [NUM_REGS-1:0] next_q;

	// ----------------------------------------------------------------
	// bus decode
	// ----------------------------------------------------------------
	logic setup;
	logic acc;
	logic wr;
	logic rd;
	logic mapped;
	logic erasing;
	logic prog_open;
	assign setup = psel && !penable && !pready;
	assign acc = psel && penable && pready;
	assign wr = acc && pwrite;
	assign rd = acc && !pwrite;
	assign erasing = (prog_state == PROG_ERASE);
	assign prog_open = (prog_state == PROG_OPEN);
	assign mapped = (paddr[1:0] == 2'h0) && (paddr <= OFS_INPUTS);

	logic start_cmd;
	logic finish_cmd;
	logic secure_cmd;
	assign start_cmd = wr && paddr == OFS_CTRL && pwdata[CTRL_START];
	assign finish_cmd = wr && paddr == OFS_CTRL && pwdata[CTRL_FINISH] && prog_open;
	assign secure_cmd = wr && paddr == OFS_CTRL && pwdata[CTRL_SECURE];

	// read mux, sampled at the setup edge
	logic [31:0] rd_mux;
	always_comb begin
		rd_mux = RST_WORD;
		unique case (paddr)
			OFS_STATUS: begin
				rd_mux[ST_ERASING] = erasing;
				rd_mux[ST_PROG_OPEN] = prog_open;
				rd_mux[ST_SECURE] = secure;
				rd_mux[ST_FULL_MAP] = full_map;
				rd_mux[ST_REFUSED] = refused;
				rd_mux[ST_POR_DONE] = !por_busy;
			end
			OFS_FUSE_ADDR: rd_mux[FUSE_AW-1:0] = fuse_addr;
			OFS_FUSE_DATA: rd_mux = secure ? RST_WORD : fuse_rdata;
			OFS_SIG_LO: rd_mux = sig[31:0];
			OFS_SIG_HI: rd_mux = sig[63:32];
			OFS_PRELOAD: rd_mux[NUM_REGS-1:0] = preload_val;
			OFS_POLARITY: rd_mux[NUM_REGS-1:0] = polarity;
			OFS_REG_STATE: rd_mux[NUM_REGS-1:0] = reg_q;
			OFS_INPUTS: rd_mux[NUM_INPUTS-1:0] = in_level;
			default: rd_mux = RST_WORD;
		endcase
	end

	// ----------------------------------------------------------------
	// apb answer: ready one cycle after setup
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= RST_WORD;
		end else if (ce) begin
			pready <= setup;
			pslverr <= setup && !mapped;
			if (setup) begin
				prdata <= (mapped && !pwrite) ? rd_mux : RST_WORD;
			end
		end
	end

	// ----------------------------------------------------------------
	// programming sequencer with automatic erase
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prog_state <= PROG_IDLE;
			erase_idx <= '0;
			full_map <= 1'b0;
		end else if (ce) begin
			unique case (prog_state)
				PROG_IDLE, PROG_OPEN: begin
					if (start_cmd) begin
						prog_state <= PROG_ERASE;
						erase_idx <= '0;
						full_map <= pwdata[CTRL_FULL_MAP];
					end else if (finish_cmd) begin
						prog_state <= PROG_IDLE;
					end
				end
				PROG_ERASE: begin
					// a new start in mid-erase restarts the sweep from word zero
					if (start_cmd) begin
						erase_idx <= '0;
						full_map <= pwdata[CTRL_FULL_MAP];
					end else begin
						erase_idx <= erase_idx + 8'h01;
						if (erase_idx == FUSE_LAST) begin
							prog_state <= PROG_OPEN;
						end
					end
				end
			endcase
		end
	end

	// security cell: set by command, cleared only by a new programming cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			secure <= 1'b0;
		end else if (ce) begin
			if (start_cmd) begin
				secure <= 1'b0;
			end else if (secure_cmd) begin
				secure <= 1'b1;
			end
		end
	end

	// fuse address pointer and refused-read flag
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fuse_addr <= '0;
			refused <= 1'b0;
		end else if (ce) begin
			if (wr && paddr == OFS_FUSE_ADDR) begin
				fuse_addr <= pwdata[FUSE_AW-1:0];
			end
			if (rd && paddr == OFS_FUSE_DATA) begin
				refused <= secure;
			end
		end
	end

	// fuse memory: erase writes zeros, programming writes data
	logic mem_we;
	logic [FUSE_AW-1:0] mem_waddr;
	logic [31:0] mem_wdata;
	assign mem_we = erasing || (wr && paddr == OFS_FUSE_DATA && prog_open && fuse_addr <= FUSE_LAST);
	assign mem_waddr = erasing ? erase_idx : fuse_addr;
	assign mem_wdata = erasing ? RST_WORD : pwdata;

	fuse_mem u_fuse_mem (
		.pclk(pclk),
		.presetn(presetn),
		.ce(ce),
		.we(mem_we),
		.waddr(mem_waddr),
		.wdata(mem_wdata),
		.raddr(fuse_addr),
		.rdata(fuse_rdata)
	);

	// user signature store and output polarity fuses
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sig <= '0;
			polarity <= RST_REGS;
		end else if (ce) begin
			if (start_cmd) begin
				sig <= '0;
				polarity <= RST_REGS;
			end else if (wr && prog_open) begin
				if (full_map && paddr == OFS_SIG_LO) begin
					sig[31:0] <= pwdata;
				end
				if (full_map && paddr == OFS_SIG_HI) begin
					sig[63:32] <= pwdata;
				end
				if (paddr == OFS_POLARITY) begin
					polarity <= pwdata[NUM_REGS-1:0];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// power-up reset and output registers
	// ----------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			por_cnt <= '0;
			por_busy <= 1'b1;
		end else if (ce && por_busy) begin
			por_cnt <= por_cnt + 7'h01;
			if (por_cnt == 7'(POR_CYCLES - 1)) begin
				por_busy <= 1'b0;
			end
		end
	end

	// preload strobe and values
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			preload_val <= RST_REGS;
			preload_go <= 1'b0;
		end else if (ce) begin
			preload_go <= wr && paddr == OFS_PRELOAD && pwdata[PRELOAD_GO];
			if (wr && paddr == OFS_PRELOAD) begin
				preload_val <= pwdata[NUM_REGS-1:0];
			end
		end
	end

	// per-register next value: power-up hold, then preload, then array logic
	genvar gi;
	generate
		for (gi = 0; gi < NUM_REGS; gi++) begin : g_reg
			always_comb begin
				if (por_busy) begin
					next_q[gi] = 1'b0;
				end else if (preload_go) begin
					next_q[gi] = preload_val[gi];
				end else begin
					next_q[gi] = next_state[gi];
				end
			end
		end
	endgenerate

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			reg_q <= RST_REGS;
			pin_out <= RST_REGS;
		end else if (ce) begin
			reg_q <= next_q;
			pin_out <= next_q ^ polarity;
		end
	end

	// input pins: undriven pins pull up to one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			in_level <= '1;
		end else if (ce) begin
			in_level <= in_val | ~in_driven;
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	sequence s_start;
		ce && start_cmd;
	endsequence
	sequence s_erase_begin;
		erasing && erase_idx == '0;
	endsequence

	a_erase_on_start: assert property (s_start |=> s_erase_begin)
		else $error("programming start did not begin erase");
	a_erase_to_open: assert property (ce && erasing && !start_cmd && erase_idx == FUSE_LAST |=> prog_open)
		else $error("erase did not end in open programming");
	a_sig_read_free: assert property (ce && setup && !pwrite && paddr == OFS_SIG_LO |=> prdata == sig[31:0])
		else $error("signature read wrong");
	a_secure_blocks_read: assert property (ce && setup && !pwrite && secure && paddr == OFS_FUSE_DATA
		|=> prdata == RST_WORD)
		else $error("protected fuse data leaked");
	a_secure_clear_path: assert property ($fell(secure) |-> $past(start_cmd))
		else $error("security cell cleared without reprogramming");
	a_sig_std_map: assert property (ce && wr && !full_map && paddr == OFS_SIG_LO |=> $stable(sig))
		else $error("signature written in standard map");
	a_preload_force: assert property (ce && preload_go && !por_busy |=> reg_q == $past(preload_val))
		else $error("preload value not taken");
	a_por_low: assert property (por_busy |-> reg_q == RST_REGS)
		else $error("register not low during power-up reset");
	a_por_bound: assert property (por_cnt <= 7'(POR_CYCLES))
		else $error("power-up reset overran its time");
	a_pin_polarity: assert property (ce && por_busy |=> pin_out == $past(polarity))
		else $error("pin level does not follow polarity");
	a_pull_up: assert property (ce && presetn |=> in_level == $past(in_val | ~in_driven))
		else $error("undriven input not read as one");
endmodule

/* rtl/cfg_store_pkg.sv */
/*
 * constants for the configuration store, security cell, preload and power-up block:
 * register offsets, field positions, fuse counts and power-up timing.
 * assumes a 100 MHz pclk and a 32-bit apb register bus.
 */
package cfg_store_pkg;
	// ----------------------------------------------------------------
	// clock and power-up timing
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 10;
	localparam int POR_TIME_NS = 1000; // longest power-up reset time
	localparam int POR_CYCLES = POR_TIME_NS / CLK_PERIOD_NS;
	localparam int POR_CNT_W = 7;

	// ----------------------------------------------------------------
	// fuse map sizes
	// ----------------------------------------------------------------
	localparam int FUSE_TOTAL = 5892; // full map, signature included
	localparam int FUSE_STANDARD = 5828; // standard map, no signature
	localparam int SIG_BITS = FUSE_TOTAL - FUSE_STANDARD;
	localparam int FUSE_WORDS = (FUSE_STANDARD + 31) / 32;
	localparam int FUSE_AW = 8;
	localparam logic [FUSE_AW-1:0] FUSE_LAST = 8'(FUSE_WORDS - 1);

	// ----------------------------------------------------------------
	// array shape
	// ----------------------------------------------------------------
	localparam int NUM_REGS = 10; // registered macrocells
	localparam int NUM_INPUTS = 22; // input and i/o pins with pull-ups

	// ----------------------------------------------------------------
	// register offsets (byte addresses)
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_STATUS = 8'h04;
	localparam logic [7:0] OFS_FUSE_ADDR = 8'h08;
	localparam logic [7:0] OFS_FUSE_DATA = 8'h0c;
	localparam logic [7:0] OFS_SIG_LO = 8'h10;
	localparam logic [7:0] OFS_SIG_HI = 8'h14;
	localparam logic [7:0] OFS_PRELOAD = 8'h18;
	localparam logic [7:0] OFS_POLARITY = 8'h1c;
	localparam logic [7:0] OFS_REG_STATE = 8'h20;
	localparam logic [7:0] OFS_INPUTS = 8'h24;

	// ----------------------------------------------------------------
	// field positions
	// ----------------------------------------------------------------
	localparam int CTRL_START = 0; // begin programming cycle
	localparam int CTRL_FINISH = 1; // close programming cycle
	localparam int CTRL_SECURE = 2; // program the security cell
	localparam int CTRL_FULL_MAP = 3; // full map with signature
	localparam int ST_ERASING = 0;
	localparam int ST_PROG_OPEN = 1;
	localparam int ST_SECURE = 2;
	localparam int ST_FULL_MAP = 3;
	localparam int ST_REFUSED = 4;
	localparam int ST_POR_DONE = 5;
	localparam int PRELOAD_GO = 16; // strobe bit in preload register

	// ----------------------------------------------------------------
	// reset values
	// ----------------------------------------------------------------
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [NUM_REGS-1:0] RST_REGS = 10'h000;
endpackage

/* rtl/fuse_mem.sv */
/*
 * word-wide fuse memory for the functional configuration map.
 * assumes one write port and one read port with registered read data.
 */
`timescale 1ns/1ps
module fuse_mem
	import cfg_store_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic ce,
	input wire logic we,
	input wire logic [FUSE_AW-1:0] waddr,
	input wire logic [31:0] wdata,
	input wire logic [FUSE_AW-1:0] raddr,
	output logic [31:0] rdata
);
	logic [31:0] mem [FUSE_WORDS];

	// write port, no reset on the array itself
	always_ff @(posedge pclk) begin
		if (ce && we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read, out of range reads as zero
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rdata <= RST_WORD;
		end else if (ce) begin
			rdata <= (raddr <= FUSE_LAST) ? mem[raddr] : RST_WORD;
		end
	end
endmodule

/* sim/prog_model.sv */
/*
 * programmer model: drives the apb side of the configuration store.
 * assumes the bench calls its tasks just after a rising pclk edge.
 */
`timescale 1ns/1ps
module prog_model (
	input wire logic pclk,
	input wire logic presetn,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// idle bus at time zero
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h0000_0000;
	end

	// one apb transfer, held until pready is seen high at an edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
			output logic [31:0] q, output logic e);
		wait (presetn === 1'b1);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		q = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		pwdata <= ~d; // released data no longer holds the last value
		@(posedge pclk);
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		logic e;
		xfer(1'b1, a, d, q, e);
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] q, output logic e);
		xfer(1'b0, a, 32'h0000_0000, q, e);
	endtask
endmodule

/* sim/cfg_store_test.sv */
/*
 * self-checking bench for the configuration store.
 * assumes prog_model as the apb master and a 100 MHz pclk.
 */
`timescale 1ns/1ps
module cfg_store_test
	import cfg_store_pkg::*;
;
	logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, q;
	logic e;
	logic [NUM_REGS-1:0] next_state, reg_q, pin_out;
	logic [NUM_INPUTS-1:0] in_val, in_driven, in_level;
	int failures = 0;
	int comparisons = 0;
	int cycles = 0;

	cfg_store cfg_store_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .next_state(next_state), .in_val(in_val), .in_driven(in_driven),
		.in_level(in_level), .reg_q(reg_q), .pin_out(pin_out));
	prog_model prog_model_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr));

	// ----------------------------------------------------------------
	// clock, timeout and reporting
	// ----------------------------------------------------------------
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end

	// cut a hang short
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 20000) begin
			failures++;
			conclude();
		end
	end

	task automatic conclude();
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic rd_check(input logic [7:0] a, input logic [31:0] exp);
		prog_model_i.rd(a, q, e);
		check(q, exp);
		check({31'h0, e}, 32'h0);
	endtask

	// poll status until programming is open again
	task automatic wait_open();
		for (int i = 0; i < 400; i++) begin
			prog_model_i.rd(OFS_STATUS, q, e);
			if (q[ST_PROG_OPEN] === 1'b1)
				return;
		end
		check(q, 32'h2);
	endtask

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		presetn = 1'b0;
		ce = 1'b0;
		next_state = '1;
		in_val = '0;
		in_driven = '1;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		ce <= 1'b1;
		// power-up hold keeps registers low
		repeat (50) @(posedge pclk);
		#1;
		check(32'(reg_q), 32'h0);
		check(32'(pin_out), 32'h0);
		@(posedge pclk);
		repeat (60) @(posedge pclk);
		rd_check(OFS_STATUS, 32'h20);
		check(32'(reg_q), 32'h3ff);
		// floating pins read high
		in_driven <= 22'h0f0f0f;
		in_val <= 22'h000000;
		next_state <= '0;
		repeat (2) @(posedge pclk);
		check(32'(in_level), 32'h3f0f0f0 & 32'h3fffff);
		rd_check(OFS_INPUTS, 32'h30f0f0);
		// unmapped and unaligned addresses
		prog_model_i.rd(8'h28, q, e);
		check({q[30:0], e}, 32'h1);
		prog_model_i.rd(8'h02, q, e);
		check({q[30:0], e}, 32'h1);
		// first programming cycle with full map
		prog_model_i.wr(OFS_CTRL, 32'h9);
		wait_open();
		prog_model_i.wr(OFS_FUSE_ADDR, 32'h0);
		prog_model_i.wr(OFS_FUSE_DATA, 32'ha5a5_5a5a);
		prog_model_i.wr(OFS_SIG_LO, 32'h1234_abcd);
		prog_model_i.wr(OFS_SIG_HI, 32'hfeed_0042);
		prog_model_i.wr(OFS_POLARITY, 32'h2a5);
		rd_check(OFS_FUSE_DATA, 32'ha5a5_5a5a);
		prog_model_i.wr(OFS_CTRL, 32'h2);
		prog_model_i.wr(OFS_CTRL, 32'h4);
		rd_check(OFS_FUSE_DATA, 32'h0);
		rd_check(OFS_STATUS, 32'h3c);
		rd_check(OFS_SIG_LO, 32'h1234_abcd);
		rd_check(OFS_SIG_HI, 32'hfeed_0042);
		// programmed polarity shows on the pins
		check(32'(pin_out), 32'h2a5);
		// preload forces a state for one edge
		prog_model_i.wr(OFS_PRELOAD, 32'h1_03c6);
		#1;
		check(32'(reg_q), 32'h3c6);
		@(posedge pclk);
		#1;
		check(32'(reg_q), 32'h0);
		@(posedge pclk);
		// reprogramming with standard map erases and clears security
		prog_model_i.wr(OFS_CTRL, 32'h1);
		wait_open();
		rd_check(OFS_STATUS, 32'h32);
		prog_model_i.wr(OFS_FUSE_ADDR, 32'h0);
		rd_check(OFS_FUSE_DATA, 32'h0);
		prog_model_i.wr(OFS_SIG_LO, 32'h5555_aaaa);
		rd_check(OFS_SIG_LO, 32'h0);
		rd_check(OFS_SIG_HI, 32'h0);
		conclude();
	end
endmodule
